/* File: rtl/interrupt_priority_resolver.sv */
// Reset-state and interrupt-priority resolver with its Wishbone register slave.
// Assumes the core supplies its condition code mask bits and samples vector_o when it services.
`timescale 1ns/1ns
`default_nettype none

module interrupt_priority_resolver
  import prio_resolver_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [DATA_W-1:0] dat_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  // Mode pins and core state.
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic global_mask_i,
  input wire logic hp_pin_mask_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic service_ack_i,
  // Non-maskable request sources.
  input wire logic ext_reset_req_i,
  input wire logic clock_fail_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_disable_i,
  input wire logic high_priority_request_pin_n_i,
  input wire logic illegal_opcode_i,
  input wire logic software_trap_i,
  // Maskable sources: external pin plus peripheral leaf flags and enables.
  input wire logic ext_request_pin_n_i,
  input wire logic [NUM_LEAVES-1:0] leaf_flag_i,
  input wire logic [NUM_LEAVES-1:0] leaf_enable_i,
  // Answer to the core.
  output logic request_valid_o,
  output logic nonmaskable_o,
  output logic [15:0] vector_o,
  // Configuration seen by the rest of the chip.
  output logic osc_startup_delay_o,
  output logic clock_monitor_enable_o,
  output logic forced_clock_monitor_enable_o,
  output logic nvm_program_enable_o,
  output logic boot_rom_visible_o,
  output logic boot_rom_hit_o,
  output op_mode_t op_mode_o
);

  // Elaboration checks on the bus shape.
  if (DATA_W != 32) begin : g_bad_data
    $error("DATA_W must be 32");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  // Register state.
  prio_mode_t prio_r;
  prio_mode_t prio_nxt;
  logic [4:0] ctrl_r;
  logic [4:0] ctrl_nxt;
  logic ack_r;
  logic [DATA_W-1:0] dat_r;
  logic ext_pin_prev_r;
  logic ext_edge_pend_r;
  logic ext_edge_pend_nxt;
  logic valid_r;
  logic nm_r;
  logic [15:0] vec_r;
  logic rom_hit_r;

  // Bus decode.
  wire logic req = cyc_i && stb_i;
  wire logic wr_go = req && we_i && ack_r && sel_i[0];
  wire logic [7:0] byte_adr = adr_i[7:0];
  wire logic hit_prio = (byte_adr == PRIO_MODE_ADDR) && (adr_i[ADDR_W-1:8] == '0);
  wire logic hit_ctrl = (byte_adr == SYS_CTRL_ADDR) && (adr_i[ADDR_W-1:8] == '0);
  wire logic hit_stat = (byte_adr == RESOLVE_STAT_ADDR) && (adr_i[ADDR_W-1:8] == '0);

  // Operating mode from the special and mode-A bits.
  wire op_mode_t mode_now = prio_r.special_variant ?
    (prio_r.mode_select_a ? MODE_TEST : MODE_BOOTSTRAP) :
    (prio_r.mode_select_a ? MODE_EXPANDED : MODE_SINGLE_CHIP);

  // Read data mux; unmapped addresses read zero.
  wire logic [DATA_W-1:0] rd_data =
    hit_prio ? {{(DATA_W-8){1'b0}}, prio_r} :
    hit_ctrl ? {{(DATA_W-5){1'b0}}, ctrl_r} :
    hit_stat ? {{(DATA_W-19){1'b0}}, mode_now, valid_r, vec_r} : '0;

  // Write path for the priority register: promotion select and the three mode bits have separate write gates.
  wire logic [7:0] wbyte = dat_i[7:0];
  wire logic promo_wr = wr_go && hit_prio && global_mask_i;
  wire logic mode_wr = wr_go && hit_prio && prio_r.special_variant;
  always_comb begin
    prio_nxt = prio_r;
    if (promo_wr) begin
      prio_nxt.promo_sel = wbyte[4:0];
    end
    if (mode_wr) begin
      prio_nxt.boot_rom_visible = wbyte[7];
      prio_nxt.special_variant = wbyte[6];
      prio_nxt.mode_select_a = wbyte[5];
    end
  end

  // System control register write.
  assign ctrl_nxt = (wr_go && hit_ctrl) ? dat_i[4:0] : ctrl_r;

  // Mode bits decoded from the pins: pin B low means special, pin A picks A.
  wire logic pin_special = !mode_pin_b_i;
  wire logic pin_boot = !mode_pin_b_i && !mode_pin_a_i;

  // Registers; the mode pins are followed throughout reset, frozen at release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_r.promo_sel <= PROMO_SEL_RESET;
      prio_r.boot_rom_visible <= pin_boot;
      prio_r.special_variant <= pin_special;
      prio_r.mode_select_a <= mode_pin_a_i;
      ctrl_r <= SYS_CTRL_RESET;
    end else begin
      prio_r <= prio_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // Wishbone acknowledge: one wait state, ack drops the cycle after it is given.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req && !ack_r;
      dat_r <= (req && !ack_r && !we_i) ? rd_data : '0;
    end
  end

  // External pin sensing: level by default, optional falling-edge latch.
  wire logic ext_level = !ext_request_pin_n_i;
  wire logic ext_fall = ext_pin_prev_r && !ext_request_pin_n_i;
  wire logic ext_serviced = service_ack_i && valid_r && !nm_r && (vec_r == VEC_EXT_PIN);
  always_comb begin
    ext_edge_pend_nxt = ext_edge_pend_r;
    if (ext_serviced) begin
      ext_edge_pend_nxt = 1'b0;
    end
    // Falls seen in level mode are not queued, so a later switch to edge mode starts clean.
    if (ext_fall && ctrl_r[CTRL_EDGE_BIT]) begin
      ext_edge_pend_nxt = 1'b1;
    end
  end
  // A fall counts at once in edge mode, so both senses answer with the same latency.
  wire logic ext_req = ctrl_r[CTRL_EDGE_BIT] ? (ext_edge_pend_r || ext_fall) : ext_level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_pin_prev_r <= 1'b1;
      ext_edge_pend_r <= 1'b0;
    end else begin
      ext_pin_prev_r <= ext_request_pin_n_i;
      ext_edge_pend_r <= ext_edge_pend_nxt;
    end
  end

  // Maskable leaf requests, each gated by its own enable; the pin has none.
  wire logic [NUM_LEAVES-1:0] leaf_req =
    {leaf_flag_i[NUM_LEAVES-1:1] & leaf_enable_i[NUM_LEAVES-1:1], ext_req};

  // Promoted slot from the select code, reserved codes included.
  wire logic [4:0] promoted = promo_slot(prio_r.promo_sel);

  // Pick the lowest-index active leaf overall and within the promoted slot.
  logic any_hit;
  logic promo_hit;
  logic [4:0] any_leaf;
  logic [4:0] promo_leaf;
  always_comb begin
    any_hit = 1'b0;
    promo_hit = 1'b0;
    any_leaf = '0;
    promo_leaf = '0;
    for (int i = NUM_LEAVES - 1; i >= 0; i--) begin
      if (leaf_req[i]) begin
        any_hit = 1'b1;
        any_leaf = 5'(i);
        if (leaf_slot(i) == promoted) begin
          promo_hit = 1'b1;
          promo_leaf = 5'(i);
        end
      end
    end
  end

  // Promotion moves one slot to the front; the rest keep default order.
  wire logic [4:0] mask_leaf = promo_hit ? promo_leaf : any_leaf;
  wire logic mask_ok = any_hit && !global_mask_i;
  wire logic [15:0] mask_vec = leaf_vector(mask_leaf);

  // Non-maskable requests; the global mask bit is never consulted here.
  nmi_req_t nmi;
  assign nmi.reset_req = ext_reset_req_i;
  assign nmi.clk_mon_req = clock_fail_i && (ctrl_r[CTRL_MON_BIT] || ctrl_r[CTRL_FMON_BIT]);
  assign nmi.watchdog_req = watchdog_timeout_i && !watchdog_disable_i;
  assign nmi.hp_pin_req = !high_priority_request_pin_n_i && !hp_pin_mask_i;
  assign nmi.illegal_req = illegal_opcode_i;
  assign nmi.sw_trap_req = software_trap_i;

  // Reset vectors move to the special page while the special bit is set.
  wire logic [7:0] rst_hi = prio_r.special_variant ? SPECIAL_VEC_HI : VEC_RESET[15:8];

  // Fixed non-maskable order, then the maskable winner.
  logic [15:0] win_vec;
  logic win_nm;
  logic win_any;
  always_comb begin
    win_nm = 1'b1;
    win_any = 1'b1;
    if (nmi.reset_req) begin
      win_vec = {rst_hi, VEC_RESET[7:0]};
    end else if (nmi.clk_mon_req) begin
      win_vec = {rst_hi, VEC_CLK_MON[7:0]};
    end else if (nmi.watchdog_req) begin
      win_vec = {rst_hi, VEC_WATCHDOG[7:0]};
    end else if (nmi.hp_pin_req) begin
      win_vec = VEC_HP_PIN;
    end else if (nmi.illegal_req) begin
      win_vec = VEC_ILLEGAL;
    end else if (nmi.sw_trap_req) begin
      win_vec = VEC_SW_TRAP;
    end else begin
      win_nm = 1'b0;
      win_any = mask_ok;
      win_vec = mask_ok ? mask_vec : '0;
    end
  end

  // Resolved answer is refreshed every cycle for the core to fetch.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_r <= 1'b0;
      nm_r <= 1'b0;
      vec_r <= '0;
    end else begin
      valid_r <= win_any;
      nm_r <= win_nm;
      vec_r <= win_vec;
    end
  end

  // Bootloader ROM window decode on the core address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rom_hit_r <= 1'b0;
    end else begin
      rom_hit_r <= prio_r.boot_rom_visible && (cpu_addr_i >= BOOT_ROM_LO) &&
        (cpu_addr_i <= BOOT_ROM_HI);
    end
  end

  // Outputs straight from flip-flops.
  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign request_valid_o = valid_r;
  assign nonmaskable_o = nm_r;
  assign vector_o = vec_r;
  assign osc_startup_delay_o = ctrl_r[CTRL_DELAY_BIT];
  assign clock_monitor_enable_o = ctrl_r[CTRL_MON_BIT];
  assign forced_clock_monitor_enable_o = ctrl_r[CTRL_FMON_BIT];
  assign nvm_program_enable_o = ctrl_r[CTRL_NVM_BIT];
  assign boot_rom_visible_o = prio_r.boot_rom_visible;
  assign boot_rom_hit_o = rom_hit_r;
  assign op_mode_o = op_mode_t'({prio_r.special_variant, prio_r.mode_select_a});

endmodule // interrupt_priority_resolver

`default_nettype wire

/* File: rtl/prio_resolver_pkg.sv */
// Constants, types and lookup functions for the interrupt priority resolver.
// Assumes a Wishbone byte address of eight bits and a core that fetches 16-bit vectors.
// Summary of operation
// - Reset loads promotion select with 00110, making the external pin top maskable.
// - After reset the external pin is sensed active-low and level-sensitive.
// - Boot, special and mode-A bits follow the mode pins as reset is released.
// - Reset sets the oscillator start-up delay bit.
// - Reset clears both clock monitor enable bits.
// - Reset disables nonvolatile programming controls; memory starts in normal read.
// - Fixed order: reset, clock monitor, watchdog, high-priority pin, illegal opcode, trap.
// - Those six sources ignore the global interrupt mask bit.
// - Maskable sources follow a fixed default order, external pin first, serial last.
// - A promoted source ranks first; the others keep their default order.
// - A promoted source is still gated by the global mask and local enables.
// - Promotion never changes any source's vector address.
// - Promotion select is writable only while the global mask bit is set.
// - Boot, special and mode-A bits are writable only while special is one.
// - Boot bit set maps the bootloader ROM at BE40 to BFFF, else absent.
// - Special and mode-A bits select one of the four operating modes.
// - Select codes 00110 to 01111 promote external pin, tick and timer1 sources.
// - Select codes 10000 to 11001 promote the remaining listed sources.
// - Reserved select codes behave as if the external pin were promoted.
// - Each source gets a two-byte vector from the fixed table.
// - Shared vectors serve serial, timer2 and timer3 groups, each leaf locally gated.
// - Servicing fetches the vector of the top pending enabled source at that moment.
// - Maskable sources are recognised only while the global mask bit is clear.
package prio_resolver_pkg;

  // Register byte addresses.
  localparam logic [7:0] PRIO_MODE_ADDR = 8'h3C;
  localparam logic [7:0] SYS_CTRL_ADDR = 8'h40;
  localparam logic [7:0] RESOLVE_STAT_ADDR = 8'h44;

  // Reset values and field positions of the system control, priority and status registers.
  localparam logic [4:0] PROMO_SEL_RESET = 5'h06;
  localparam int CTRL_DELAY_BIT = 0;
  localparam int CTRL_MON_BIT = 1;
  localparam int CTRL_FMON_BIT = 2;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_NVM_BIT = 4;
  localparam logic [4:0] SYS_CTRL_RESET = 5'h01;
  localparam int STAT_VALID_BIT = 16;
  localparam int STAT_MODE_LSB = 17;

  // Bootloader ROM window.
  localparam logic [15:0] BOOT_ROM_LO = 16'hBE40;
  localparam logic [15:0] BOOT_ROM_HI = 16'hBFFF;

  // Non-maskable vectors, plus the maskable external pin vector.
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_CLK_MON = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG = 16'hFFFA;
  localparam logic [15:0] VEC_ILLEGAL = 16'hFFF8;
  localparam logic [15:0] VEC_SW_TRAP = 16'hFFF6;
  localparam logic [15:0] VEC_HP_PIN = 16'hFFF4;
  localparam logic [15:0] VEC_EXT_PIN = 16'hFFF2;
  localparam logic [7:0] SPECIAL_VEC_HI = 8'hBF;

  // Maskable leaf sources and priority slots.
  localparam int NUM_LEAVES = 29;
  localparam int NUM_SLOTS = 20;

  // Operating modes selected by special and mode-A bits.
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_EXPANDED,
    MODE_BOOTSTRAP,
    MODE_TEST
  } op_mode_t;

  // The priority and mode register layout.
  typedef struct packed {
    logic boot_rom_visible;
    logic special_variant;
    logic mode_select_a;
    logic [4:0] promo_sel;
  } prio_mode_t;

  // Non-maskable requests as seen by the resolver.
  typedef struct packed {
    logic reset_req;
    logic clk_mon_req;
    logic watchdog_req;
    logic hp_pin_req;
    logic illegal_req;
    logic sw_trap_req;
  } nmi_req_t;

  // Priority slot of each maskable leaf, in default order.
  function automatic logic [4:0] leaf_slot(input int leaf);
    logic [4:0] s;
    if (leaf <= 9) s = 5'(leaf);
    else if (leaf <= 12) s = 5'h0A;
    else if (leaf <= 17) s = 5'(leaf - 2);
    else if (leaf <= 21) s = 5'h10;
    else if (leaf == 22) s = 5'h11;
    else if (leaf == 23) s = 5'h12;
    else s = 5'h13;
    return s;
  endfunction

  // Fixed vector of each maskable leaf; shared groups return one address.
  function automatic logic [15:0] leaf_vector(input logic [4:0] leaf);
    logic [15:0] v;
    unique case (leaf)
      5'h00: v = VEC_EXT_PIN;
      5'h01: v = 16'hFFF0;
      5'h02: v = 16'hFFEE;
      5'h03: v = 16'hFFEC;
      5'h04: v = 16'hFFEA;
      5'h05: v = 16'hFFE8;
      5'h06: v = 16'hFFE6;
      5'h07: v = 16'hFFE4;
      5'h08: v = 16'hFFE2;
      5'h09: v = 16'hFFE0;
      5'h0A, 5'h0B, 5'h0C: v = 16'hFFD4;
      5'h0D: v = 16'hFFD2;
      5'h0E: v = 16'hFFDE;
      5'h0F: v = 16'hFFD0;
      5'h10: v = 16'hFFDC;
      5'h11: v = 16'hFFDA;
      5'h12, 5'h13, 5'h14: v = 16'hFFCE;
      5'h15, 5'h16: v = 16'hFFCC;
      5'h17: v = 16'hFFD8;
      default: v = 16'hFFD6;
    endcase
    return v;
  endfunction

  // Slot promoted by a select code; reserved codes fall back to the external pin.
  function automatic logic [4:0] promo_slot(input logic [4:0] code);
    logic [4:0] s;
    unique case (code)
      5'h06: s = 5'h00;
      5'h07: s = 5'h01;
      5'h08, 5'h09, 5'h0A: s = code - 5'h06;
      5'h0B, 5'h0C, 5'h0D, 5'h0E: s = code - 5'h06;
      5'h0F: s = 5'h09;
      5'h10: s = 5'h0C;
      5'h11: s = 5'h0E;
      5'h12: s = 5'h0F;
      5'h13: s = 5'h12;
      5'h14: s = 5'h13;
      5'h15: s = 5'h0A;
      5'h16: s = 5'h0B;
      5'h17: s = 5'h0D;
      5'h18: s = 5'h10;
      5'h19: s = 5'h11;
      default: s = 5'h00;
    endcase
    return s;
  endfunction

endpackage

/* File: tb/core_model.sv */
// Behavioural processor core that services the resolver's vectored requests.
// Assumes request_valid_i and vector_i come straight from the resolver.
`timescale 1ns/1ns
`default_nettype none
module core_model #(
  parameter int LAT = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Resolver answer.
  input wire logic request_valid_i,
  input wire logic [15:0] vector_i,
  // Service handshake back to the resolver.
  output logic service_ack_o,
  output logic [15:0] last_vec_o
);
  int cnt_r;
  // Waits LAT cycles of a standing request, then fetches the vector shown at that moment.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 0;
      service_ack_o <= 1'b0;
      last_vec_o <= 16'h0000;
    end else begin
      service_ack_o <= 1'b0;
      if (request_valid_i && !service_ack_o && cnt_r == LAT) begin
        service_ack_o <= 1'b1;
        last_vec_o <= vector_i;
        cnt_r <= 0;
      end else begin
        cnt_r <= request_valid_i ? cnt_r + 1 : 0;
      end
    end
  end
endmodule // core_model
`default_nettype wire

/* File: tb/resolver_monitor.sv */
// Concurrent checks on the resolver's request and mode ports.
// Assumes it is bound into the resolver top module by name.
`timescale 1ns/1ns
`default_nettype none
module resolver_monitor
  import prio_resolver_pkg::*;
(
  // Watched inputs.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic global_mask_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic ext_reset_req_i,
  input wire logic clock_fail_i,
  input wire logic watchdog_timeout_i,
  input wire logic high_priority_request_pin_n_i,
  input wire logic illegal_opcode_i,
  input wire logic software_trap_i,
  input wire logic ext_request_pin_n_i,
  input wire logic [NUM_LEAVES-1:0] leaf_flag_i,
  input wire logic [NUM_LEAVES-1:0] leaf_enable_i,
  // Watched outputs.
  input wire logic request_valid_o,
  input wire logic nonmaskable_o,
  input wire logic [15:0] vector_o,
  input wire logic boot_rom_visible_o,
  input wire logic boot_rom_hit_o,
  input wire op_mode_t op_mode_o
);
  wire logic hi_nmi;
  wire logic leaf_any;
  // Any source above the trap, counted even when its own gate might hold it back.
  assign hi_nmi = ext_reset_req_i | clock_fail_i | watchdog_timeout_i
                  | !high_priority_request_pin_n_i | illegal_opcode_i;
  assign leaf_any = |(leaf_flag_i[NUM_LEAVES-1:1] & leaf_enable_i[NUM_LEAVES-1:1]);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Property declarations.
  property p_reset_wins; ext_reset_req_i |=> nonmaskable_o && vector_o[7:0] == 8'hFE; endproperty
  property p_trap_nmi; software_trap_i |=> request_valid_o && nonmaskable_o; endproperty
  property p_trap_vec; software_trap_i && !hi_nmi |=> vector_o == VEC_SW_TRAP; endproperty
  property p_masked_quiet;
    global_mask_i && !hi_nmi && !software_trap_i |=> !request_valid_o;
  endproperty
  property p_ext_pin;
    $fell(ext_request_pin_n_i) && !global_mask_i && !hi_nmi && !software_trap_i && !leaf_any
      |=> vector_o == VEC_EXT_PIN;
  endproperty
  property p_leaf_req;
    !global_mask_i && !hi_nmi && !software_trap_i && leaf_any |=> request_valid_o && !nonmaskable_o;
  endproperty
  property p_boot_hit;
    boot_rom_visible_o && cpu_addr_i >= BOOT_ROM_LO && cpu_addr_i <= BOOT_ROM_HI |=> boot_rom_hit_o;
  endproperty
  property p_boot_miss; cpu_addr_i > BOOT_ROM_HI |=> !boot_rom_hit_o; endproperty
  property p_mode_latch;
    $fell(rst_i) |-> op_mode_o == {!$past(mode_pin_b_i), $past(mode_pin_a_i)};
  endproperty
  // Assertions.
  a_reset_wins: assert property (p_reset_wins) else $error("reset request lost");
  a_trap_nmi: assert property (p_trap_nmi) else $error("trap not taken");
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked request seen");
  a_ext_pin: assert property (p_ext_pin) else $error("external pin vector wrong");
  a_leaf_req: assert property (p_leaf_req) else $error("maskable request lost");
  a_boot_hit: assert property (p_boot_hit) else $error("boot window missed");
  a_boot_miss: assert property (p_boot_miss) else $error("boot window too wide");
  a_mode_latch: assert property (p_mode_latch) else $error("mode bits not latched");
  // Main scenarios reached.
  c_trap: cover property (software_trap_i ##1 nonmaskable_o);
  c_boot: cover property (boot_rom_hit_o);
  c_mask: cover property (request_valid_o && !nonmaskable_o);
endmodule // resolver_monitor
bind interrupt_priority_resolver resolver_monitor u_resolver_monitor (.*);
`default_nettype wire

/* File: tb/tb_interrupt_priority_resolver.sv */
// Self-checking bench for the interrupt priority resolver.
// Assumes a Wishbone register slave answering within a few cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_priority_resolver;
  import prio_resolver_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic mode_pin_a_i = 0, mode_pin_b_i = 0, global_mask_i = 1, hp_pin_mask_i = 0;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic ext_reset_req_i = 0, clock_fail_i = 0, watchdog_timeout_i = 0, watchdog_disable_i = 0;
  logic illegal_opcode_i = 0, software_trap_i = 0;
  logic high_priority_request_pin_n_i = 1, ext_request_pin_n_i = 1;
  logic [NUM_LEAVES-1:0] leaf_flag_i = '0, leaf_enable_i = '0;
  wire logic [31:0] dat_o;
  wire logic ack_o, request_valid_o, nonmaskable_o, service_ack_i;
  wire logic [15:0] vector_o, core_vec;
  wire logic osc_startup_delay_o, clock_monitor_enable_o, forced_clock_monitor_enable_o;
  wire logic nvm_program_enable_o, boot_rom_visible_o, boot_rom_hit_o;
  wire op_mode_t op_mode_o;
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  // Slot promoted by each select code, and low vector byte of each leaf.
  int pmap[32] = '{0,0,0,0,0,0,0,1,2,3,4,5,6,7,8,9,12,14,15,18,19,10,11,13,16,17,0,0,0,0,0,0};
  logic [7:0] vlo[29] = '{8'hF2,8'hF0,8'hEE,8'hEC,8'hEA,8'hE8,8'hE6,8'hE4,8'hE2,8'hE0,
    8'hD4,8'hD4,8'hD4,8'hD2,8'hDE,8'hD0,8'hDC,8'hDA,8'hCE,8'hCE,8'hCE,8'hCC,8'hCC,8'hD8,
    8'hD6,8'hD6,8'hD6,8'hD6,8'hD6};
  logic [7:0] nv[6] = '{8'hFE,8'hFC,8'hFA,8'hF4,8'hF8,8'hF6};
  interrupt_priority_resolver u_interrupt_priority_resolver (.*);
  core_model #(.LAT(2)) u_core_model (.clk_i(clk_i), .rst_i(rst_i),
    .request_valid_i(request_valid_o), .vector_i(vector_o),
    .service_ack_o(service_ack_i), .last_vec_o(core_vec));
  // Clock and hang guard.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      conclude();
    end
  end
  // Default priority slot of a maskable leaf.
  function automatic int slot(input int l);
    return l < 10 ? l : l < 13 ? 10 : l < 18 ? l - 2 : l < 22 ? 16 : l < 24 ? l - 5 : 19;
  endfunction
  // Expected winner vector, zero when nothing may be recognised.
  function automatic logic [15:0] model(input int code);
    int best, bk, key;
    best = -1;
    bk = 99;
    for (int l = 0; l < NUM_LEAVES; l++) begin
      if (l == 0 ? !ext_request_pin_n_i : (leaf_flag_i[l] & leaf_enable_i[l])) begin
        key = (slot(l) == pmap[code]) ? -1 : slot(l);
        if (key < bk) begin
          bk = key;
          best = l;
        end
      end
    end
    if (global_mask_i || best < 0) return 16'h0000;
    return {8'hFF, vlo[best]};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic Wishbone cycle; read data taken at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    if (n >= 50) chk("ack", 16'h0001, 16'h0000);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence.
  initial begin
    logic [7:0] q;
    logic [5:0] act;
    void'($urandom(43));
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("op_mode", 16'h0002, 16'(op_mode_o));
    chk("delay", 16'h0001, 16'(osc_startup_delay_o));
    chk("clkmon", 16'h0000, {14'h0, clock_monitor_enable_o, forced_clock_monitor_enable_o});
    chk("nvm", 16'h0000, 16'(nvm_program_enable_o));
    chk("boot_vis", 16'h0001, 16'(boot_rom_visible_o));
    wb(0, PRIO_MODE_ADDR, 8'h00, q);
    chk("prio", 16'h00C6, 16'(q));
    wb(0, SYS_CTRL_ADDR, 8'h00, q);
    chk("ctrl", 16'h0001, 16'(q));
    wb(0, 8'h80, 8'h00, q);
    chk("unmapped", 16'h0000, 16'(q));
    cpu_addr_i <= BOOT_ROM_HI;
    settle();
    chk("boot_hit", 16'h0001, 16'(boot_rom_hit_o));
    $display("test reset state done");
    global_mask_i <= 0;
    wb(1, PRIO_MODE_ADDR, 8'hC7, q);
    wb(0, PRIO_MODE_ADDR, 8'h00, q);
    chk("prio", 16'h00C6, 16'(q));
    global_mask_i <= 1;
    wb(1, PRIO_MODE_ADDR, 8'h27, q);
    wb(1, PRIO_MODE_ADDR, 8'hE6, q);
    wb(0, PRIO_MODE_ADDR, 8'h00, q);
    chk("prio", 16'h0026, 16'(q));
    chk("op_mode", 16'h0001, 16'(op_mode_o));
    chk("boot_vis", 16'h0000, 16'(boot_rom_visible_o));
    cpu_addr_i <= 16'hBE40;
    settle();
    chk("boot_hit", 16'h0000, 16'(boot_rom_hit_o));
    $display("test write gates done");
    for (int code = 0; code < 32; code++) begin
      global_mask_i <= 1;
      wb(1, PRIO_MODE_ADDR, {3'b001, 5'(code)}, q);
      for (int t = 0; t < 8; t++) begin
        leaf_flag_i <= 29'($urandom & $urandom & $urandom);
        leaf_enable_i <= 29'($urandom | $urandom);
        ext_request_pin_n_i <= 1'($urandom);
        global_mask_i <= (t == 7);
        settle();
        chk("vector", model(code), vector_o);
        chk("valid", 16'(model(code) != 0), 16'(request_valid_o));
        chk("nonmask", 16'h0000, 16'(nonmaskable_o));
      end
    end
    $display("test promotion sweep done");
    leaf_flag_i <= '0;
    ext_request_pin_n_i <= 1;
    wb(1, SYS_CTRL_ADDR, 8'h09, q);
    global_mask_i <= 0;
    ext_request_pin_n_i <= 0;
    settle();
    ext_request_pin_n_i <= 1;
    settle();
    chk("edge_vec", VEC_EXT_PIN, vector_o);
    repeat (8) @(posedge clk_i);
    chk("edge_clear", 16'h0000, 16'(request_valid_o));
    chk("edge_core", VEC_EXT_PIN, core_vec);
    global_mask_i <= 1;
    $display("test edge mode done");
    leaf_flag_i <= '1;
    leaf_enable_i <= '1;
    clock_fail_i <= 1;
    settle();
    chk("clkmon_off", 16'h0000, 16'(request_valid_o));
    {watchdog_timeout_i, watchdog_disable_i} <= 2'b11;
    {high_priority_request_pin_n_i, hp_pin_mask_i} <= 2'b01;
    settle();
    chk("nmi_gated", 16'h0000, 16'(request_valid_o));
    {watchdog_disable_i, hp_pin_mask_i} <= 2'b00;
    wb(1, SYS_CTRL_ADDR, 8'h03, q);
    for (int k = 5; k >= 0; k--) begin
      act = 6'h3F >> k;
      {ext_reset_req_i, clock_fail_i, watchdog_timeout_i} <= act[5:3];
      high_priority_request_pin_n_i <= !act[2];
      {illegal_opcode_i, software_trap_i} <= act[1:0];
      settle();
      chk("nmi_vec", {8'hFF, nv[k]}, vector_o);
      chk("nmi", 16'h0001, 16'(nonmaskable_o));
    end
    wb(0, RESOLVE_STAT_ADDR, 8'h00, q);
    chk("stat", 16'h00FE, 16'(q));
    repeat (5) @(posedge clk_i);
    chk("core_vec", 16'hFFFE, core_vec);
    $display("test fixed order done");
    conclude();
  end
endmodule // tb_interrupt_priority_resolver
`default_nettype wire
